/* File: verif/cable_engine_model.sv */
`timescale 1ns/1ps
// Behavioural stand-in for the analog cable test engine on the far side.
module cable_engine_model #(
  parameter int DELAY = 8
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Request from the block and outcome chosen by the bench.
  input wire logic test_req_i,
  input wire logic [1:0] code_i,
  input wire logic [8:0] count_i,
  // Answer to the block.
  output logic done_o,
  output logic [1:0] result_o,
  output logic [8:0] fault_count_o
);
  int cnt; // Cycles spent measuring.

  // Finishes a test DELAY cycles after the request and reports one pulse.
  // Outside that pulse the outcome lines toggle, so stale capture shows up.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      done_o <= 1'b0;
      result_o <= 2'h0;
      fault_count_o <= 9'h000;
    end else begin
      cnt <= test_req_i ? cnt + 1 : 0;
      done_o <= test_req_i && cnt == DELAY - 1;
      if (test_req_i && cnt == DELAY - 1) begin
        result_o <= code_i;
        fault_count_o <= count_i;
      end else begin
        result_o <= ~result_o;
        fault_count_o <= ~fault_count_o;
      end
    end
  end
endmodule : cable_engine_model

/* File: verif/port_phy_checker.sv */
`timescale 1ns/1ps
// Watches the register bus answer and the control outputs of the bank.
module port_phy_checker #(
  parameter int LED_N = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic cable_test_req_o,
  input wire logic cable_test_done_i,
  input wire logic link_detect_i,
  input wire logic link_pass_o,
  input wire logic an_restart_o,
  input wire logic [LED_N-1:0] led_req_n_i,
  input wire logic [LED_N-1:0] port_led_n_o
);
  // A frozen clock enable stalls everything, so checks pause with it.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  // Edge at which a write commits, and the same for two registers.
  sequence s_commit;
    psel_i && penable_i && pready_o && pwrite_i;
  endsequence
  sequence s_restart_write;
    s_commit ##0 (paddr_i == 12'h3D8 && pwdata_i[13]);
  endsequence
  sequence s_test_start;
    s_commit ##0 (paddr_i == 12'h3D0 && pwdata_i[12]);
  endsequence

  a_ready_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready did not follow the single wait state");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready stood longer than one cycle");
  a_error_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
  a_rdata_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data not zero outside ready");
  a_upper_half_zero: assert property (prdata_o[31:16] == 16'h0000)
    else $error("upper read data bits not zero");
  a_restart_fires: assert property (s_restart_write |=> an_restart_o)
    else $error("restart pulse missing after write");
  a_restart_cause: assert property (an_restart_o |-> $past(pready_o && pwrite_i && paddr_i == 12'h3D8 && pwdata_i[13]))
    else $error("restart pulse without a write");
  a_link_detect_pass: assert property (link_detect_i |=> link_pass_o)
    else $error("detected link not passed");
  a_test_starts: assert property (s_test_start |=> cable_test_req_o)
    else $error("cable test did not start");
  a_test_ends: assert property (cable_test_req_o && cable_test_done_i && !pready_o |=> !cable_test_req_o)
    else $error("cable test did not end on done");
  a_led_request: assert property ((~port_led_n_o & $past(led_req_n_i)) == '0)
    else $error("led lit without a request");
endmodule : port_phy_checker

bind port_phy_control_status port_phy_checker #(.LED_N(LED_N)) chk_u (.clk_sys_i, .rst_n_i, .ce_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
  .cable_test_req_o, .cable_test_done_i, .link_detect_i, .link_pass_o, .an_restart_o,
  .led_req_n_i, .port_led_n_o);

/* File: verif/port_phy_control_status_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin failures++; $display("unexpected %s expected %h seen %h", n, e, a); end end
// Register bank bench.
module port_phy_control_status_tb;
  import pphy_pkg::*;
  // Byte addresses; the unmapped one sits between two registers.
  localparam logic [11:0] A_CD = {IDX_CABLE_DIAG, 2'b00};
  localparam logic [11:0] A_PC = {IDX_PORT_CTRL, 2'b00};
  localparam logic [11:0] A_PS = {IDX_PORT_STAT, 2'b00};
  localparam logic [11:0] A_BAD = 12'h3D4;
  logic clk_sys_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, r;
  logic pready_o, pslverr_o, e, req, done;
  logic [1:0] cres, code = 0;
  logic [8:0] ccnt, cnt9 = 0;
  logic link_detect_i = 0, an_done_i = 0, an_fail_i = 0, sensed_speed_100_i = 0, auto_mdi_i = 1, polarity_rev_i = 0;
  logic [4:0] partner_i = 0, adv_o;
  logic [3:0] led_req_n_i = 0, port_led_n_o;
  logic link_pass_o, remote_loop_o, tx_disable_o, an_restart_o, an_enable_o, auto_mdix_en_o;
  logic crossover_variant_select_o, speed_100_o, full_duplex_o, mdi_o;
  int failures = 0, checked = 0, n;

  // Free-running 50 MHz system clock.
  always #10 clk_sys_i = ~clk_sys_i;

  port_phy_control_status dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cable_test_req_o(req),
    .cable_test_done_i(done), .cable_result_i(cres), .cable_fault_count_i(ccnt), .link_detect_i(link_detect_i),
    .an_done_i(an_done_i), .an_fail_i(an_fail_i), .sensed_speed_100_i(sensed_speed_100_i),
    .auto_mdi_i(auto_mdi_i), .polarity_rev_i(polarity_rev_i), .partner_i(partner_i),
    .led_req_n_i(led_req_n_i), .port_led_n_o(port_led_n_o), .link_pass_o(link_pass_o),
    .remote_loop_o(remote_loop_o), .tx_disable_o(tx_disable_o), .an_restart_o(an_restart_o),
    .an_enable_o(an_enable_o), .adv_o(adv_o), .auto_mdix_en_o(auto_mdix_en_o),
    .crossover_variant_select_o(crossover_variant_select_o), .speed_100_o(speed_100_o),
    .full_duplex_o(full_duplex_o), .mdi_o(mdi_o));

  cable_engine_model #(.DELAY(8)) eng_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .test_req_i(req),
    .code_i(code), .count_i(cnt9), .done_o(done), .result_o(cres), .fault_count_o(ccnt));

  // One bus transfer; the request holds until ready is seen at an edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k == 50) failures++;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    `CHK("write error", 1'b0, e)
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    `CHK("read data", x, r)
  endtask : rd

  // Lets registered outputs and the resolver catch up, then samples mid-cycle.
  task automatic settle;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : settle

  task automatic report_and_stop;
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Cuts a hang short; the tests take well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(A_CD, 32'h0000);
    rd(A_PC, 32'h00FF);
    rd(A_PS, 32'h8080);
    xfer(1'b0, A_BAD, 32'h0);
    `CHK("unmapped error", 1'b1, e)
    wr(A_PS, 32'h7FFF);
    rd(A_PS, 32'h0080);
    `CHK("variant", 1'b0, crossover_variant_select_o)
    wr(A_PC, 32'hFFFF);
    settle();
    rd(A_PC, 32'hE6FF);
    `CHK("leds", 4'hF, port_led_n_o)
    `CHK("tx disable", 1'b1, tx_disable_o)
    `CHK("auto mdix", 1'b0, auto_mdix_en_o)
    wr(A_PC, 32'h0400);
    led_req_n_i <= 4'hA;
    settle();
    `CHK("leds", 4'hA, port_led_n_o)
    `CHK("advert", 5'h00, adv_o)
    `CHK("an enable", 1'b0, an_enable_o)
    rd(A_PS, 32'h0000);
    `CHK("mdi", 1'b0, mdi_o)
    wr(A_PC, 32'h0660);
    settle();
    rd(A_PS, 32'h0680);
    wr(A_PC, 32'h009F);
    an_fail_i <= 1'b1;
    sensed_speed_100_i <= 1'b1;
    settle();
    `CHK("duplex", 1'b0, full_duplex_o)
    `CHK("speed", 1'b1, speed_100_o)
    @(posedge clk_sys_i);
    an_fail_i <= 1'b0;
    an_done_i <= 1'b1;
    partner_i <= 5'h0A;
    polarity_rev_i <= 1'b1;
    link_detect_i <= 1'b1;
    settle();
    rd(A_PS, 32'h26EA);
    link_detect_i <= 1'b0;
    wr(A_CD, 32'h0A00);
    settle();
    `CHK("link pass", 1'b1, link_pass_o)
    `CHK("remote loop", 1'b1, remote_loop_o)
    rd(A_CD, 32'h0A00);
    // Every outcome code, each with its own distance.
    for (int i = 0; i < 4; i++) begin
      code <= i[1:0];
      cnt9 <= {i[1:0], 7'h2A};
      wr(A_CD, 32'h1000);
      rd(A_CD, (i == 0) ? 32'h1000 : {17'h0, i[1:0] - 2'h1, 4'h8, i[1:0] - 2'h1, 7'h2A});
      n = 0;
      while (req !== 1'b0 && n < 100) begin
        @(posedge clk_sys_i);
        n++;
      end
      if (n == 100) failures++;
      rd(A_CD, {17'h0, i[1:0], 4'h0, i[1:0], 7'h2A});
    end
    report_and_stop();
  end
endmodule : port_phy_control_status_tb

/* File: verilog/cable_diag_seq.sv */
`timescale 1ns/1ps
// Runs one cable test: raises the request to the analog side, waits for its
// done strobe, captures outcome and distance, then drops the busy flag.
module cable_diag_seq #(
  parameter int FAULT_W = 9
) (
  // Clock, reset and enable.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Software side.
  input wire logic start_i,
  output logic busy_o,
  output logic [1:0] result_o,
  output logic [FAULT_W-1:0] fault_count_o,
  // Analog measurement side.
  output logic test_req_o,
  input wire logic done_i,
  input wire logic [1:0] result_i,
  input wire logic [FAULT_W-1:0] fault_count_i
);
  import pphy_pkg::*;

  // The busy flag is the test-enable bit; a new start wins over a finishing test.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      test_req_o <= 1'b0;
    end else if (ce_i) begin
      if (start_i) begin
        busy_o <= 1'b1;
        test_req_o <= 1'b1;
      end else if (busy_o && done_i) begin
        busy_o <= 1'b0;
        test_req_o <= 1'b0;
      end
    end
  end

  // Results are caught only when a running test ends, so they stay stable between tests.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o <= CABLE_NORMAL;
      fault_count_o <= '0;
    end else if (ce_i && busy_o && done_i && !start_i) begin
      result_o <= result_i;
      fault_count_o <= fault_count_i;
    end
  end
endmodule : cable_diag_seq

/* File: verilog/link_mode_resolve.sv */
`timescale 1ns/1ps
// Resolves operating speed, duplex and crossover from control bits and what
// the line side reports. All outputs are registered.
module link_mode_resolve (
  // Clock, reset and enable.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Control bits.
  input wire logic an_en_i,
  input wire logic force_speed_i,
  input wire logic force_duplex_i,
  input wire logic mdix_dis_i,
  input wire logic force_mdi_i,
  input wire logic [pphy_pkg::ADV_W-1:0] adv_i,
  // Line side.
  input wire logic [pphy_pkg::ADV_W-1:0] partner_i,
  input wire logic an_done_i,
  input wire logic an_fail_i,
  input wire logic sensed_speed_100_i,
  input wire logic auto_mdi_i,
  // Results.
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic mdi_o
);
  import pphy_pkg::*;

  logic [ADV_W-1:0] common; // Abilities both ends offer.

  assign common = adv_i & partner_i;

  // Pick the best common mode on success; forced values with negotiation off; on failure sensed speed and forced duplex.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_100_o <= 1'b0;
      full_duplex_o <= 1'b0;
    end else if (ce_i) begin
      if (!an_en_i) begin
        speed_100_o <= force_speed_i;
        full_duplex_o <= force_duplex_i;
      end else if (an_done_i) begin
        speed_100_o <= common[AB_100F] | common[AB_100H];
        full_duplex_o <= common[AB_100F] | (~common[AB_100H] & common[AB_10F]);
      end else if (an_fail_i) begin
        // Parallel detection gives speed only, so duplex is forced.
        speed_100_o <= sensed_speed_100_i;
        full_duplex_o <= force_duplex_i;
      end
    end
  end

  // Crossover: forced when automatic selection is off, else follow the line.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mdi_o <= RST_MDI;
    end else if (ce_i) begin
      mdi_o <= mdix_dis_i ? force_mdi_i : auto_mdi_i;
    end
  end
endmodule : link_mode_resolve

/* File: verilog/port_phy_control_status.sv */
// How it works
// - Two-bit cable result: normal, open, short, failed.
// - Writing one starts test; self-clears when done.
// - Nine-bit fault distance, about 0.4 m each.
// - Force-link bit makes link always pass.
// - Remote loopback returns receive pair to transmit.
// - LED-off drives all four LEDs high.
// - Transmit-disable bit turns off the transmitter.
// - Writing one restarts autonegotiation.
// - Crossover-disable stops automatic MDI/MDI-X selection.
// - Forced crossover: one MDI, zero MDI-X.
// - Autonegotiation enabled by default; else forced bits.
// - Forced speed: one 100, zero 10 Mbps.
// - Forced duplex when negotiation off or failed.
// - Five advertisement bits, all reset to one.
// - Writable crossover variant bit, resets to one.
// - Read-only reversed receive polarity flag.
// - Read-only resolved speed and duplex bits.
// - Read-only crossover state, one is MDI.
// - Read-only negotiation done and link good.
// - Read-only link partner ability bits.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module port_phy_control_status #(
  parameter int FAULT_W = 9,
  parameter int LED_N = 4
) (
  // Clock, reset and enable.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pphy_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [pphy_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [pphy_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Cable diagnostic engine.
  output logic cable_test_req_o,
  input wire logic cable_test_done_i,
  input wire logic [1:0] cable_result_i,
  input wire logic [FAULT_W-1:0] cable_fault_count_i,
  // Line status from the PHY core.
  input wire logic link_detect_i,
  input wire logic an_done_i,
  input wire logic an_fail_i,
  input wire logic sensed_speed_100_i,
  input wire logic auto_mdi_i,
  input wire logic polarity_rev_i,
  input wire logic [pphy_pkg::ADV_W-1:0] partner_i,
  // LED requests, active low.
  input wire logic [LED_N-1:0] led_req_n_i,
  // PHY controls.
  output logic [LED_N-1:0] port_led_n_o,
  output logic link_pass_o,
  output logic remote_loop_o,
  output logic tx_disable_o,
  output logic an_restart_o,
  output logic an_enable_o,
  output logic [pphy_pkg::ADV_W-1:0] adv_o,
  output logic auto_mdix_en_o,
  output logic crossover_variant_select_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic mdi_o
);
  import pphy_pkg::*;

  // Refuse widths that the register layout cannot hold.
  // Other widths need a new layout.
  if (FAULT_W != pphy_pkg::FAULT_W) begin : g_bad_fault_w
    $error("Fault count width must match the register field.");
  end
  if (LED_N != pphy_pkg::LED_N) begin : g_bad_led_n
    $error("The port has exactly four LED outputs.");
  end

  // Stored control bits; each has exactly one flop, shared by every alias.
  // Reserved bits have no flop.
  logic force_link; // Link forced to pass.
  logic remote_loop; // Remote loopback.
  logic led_off; // All LEDs off.
  logic tx_dis; // Transmitter disabled.
  logic an_restart; // Restart bit as last written.
  logic mdix_dis; // Automatic crossover disabled.
  logic force_mdi; // Forced crossover choice.
  logic an_en; // Autonegotiation enable.
  logic force_speed; // Forced speed, one is 100 Mbps.
  logic force_duplex; // Forced duplex, one is full.
  logic [ADV_W-1:0] adv; // Advertised abilities.
  logic xover_variant; // Crossover algorithm variant.

  // Captured line status.
  // Sampled so reads see settled values.
  logic polarity_rev; // Receive polarity reversed.
  logic an_done; // Negotiation complete.
  logic [ADV_W-1:0] partner; // Partner abilities.

  // Cable test state from the sequencer.
  logic test_busy; // Test-enable bit.
  logic [1:0] cable_result; // Last outcome.
  logic [FAULT_W-1:0] fault_count; // Last fault distance.

  // Bus decode.
  // The whole address must match.
  logic access; // Access phase present.
  logic commit; // Transfer completes at this edge.
  logic hit_cable; // Address is the cable diagnostic register.
  logic hit_ctrl; // Address is the port control register.
  logic hit_stat; // Address is the port status register.
  logic mapped; // Address is one of ours.
  logic wr_ok; // A mapped write completes now.
  logic [REG_W-1:0] wmask; // Bits covered by the byte strobes.
  logic [REG_W-1:0] rd_word; // Read value of the addressed register.
  logic cable_start; // Software requests a cable test.

  // Expand the low two strobes into a 16-bit write mask.
  function automatic logic [REG_W-1:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  // Merge masked write data into a stored field.
  // A strobe-less byte keeps its value.
  function automatic logic merge(input logic old_v, input logic new_v, input logic en);
    merge = en ? new_v : old_v;
  endfunction : merge

  // A transfer commits at the ready edge;
  // write and read data both belong to it.
  assign access = psel_i & penable_i;
  assign commit = access & pready_o;
  assign hit_cable = paddr_i == reg_addr(IDX_CABLE_DIAG);
  assign hit_ctrl = paddr_i == reg_addr(IDX_PORT_CTRL);
  assign hit_stat = paddr_i == reg_addr(IDX_PORT_STAT);
  assign mapped = hit_cable | hit_ctrl | hit_stat;
  assign wr_ok = commit & pwrite_i & mapped;
  assign wmask = lane_mask(pstrb_i);
  // A start needs its byte strobe.
  assign cable_start = wr_ok & hit_cable & wmask[CD_TEST_EN] & pwdata_i[CD_TEST_EN];

  // Read words; reserved and unmodelled bits read as zero.
  // Speed, duplex, crossover and link-good status bits mirror the registered pins.
  always_comb begin
    rd_word = '0;
    if (hit_cable) begin
      rd_word[CD_RESULT_LO +: 2] = cable_result;
      rd_word[CD_TEST_EN] = test_busy;
      rd_word[CD_FORCE_LINK] = force_link;
      rd_word[CD_REMOTE_LOOP] = remote_loop;
      rd_word[CD_FAULT_LO +: FAULT_W] = fault_count;
    end else if (hit_ctrl) begin
      rd_word[PC_LED_OFF] = led_off;
      rd_word[PC_TX_DIS] = tx_dis;
      rd_word[PC_AN_RESTART] = an_restart;
      rd_word[PC_MDIX_DIS] = mdix_dis;
      rd_word[PC_FORCE_MDI] = force_mdi;
      rd_word[PC_AN_EN] = an_en;
      rd_word[PC_FORCE_SPEED] = force_speed;
      rd_word[PC_FORCE_DUPLEX] = force_duplex;
      rd_word[PC_ADV_LO +: ADV_W] = adv;
      // Reserved control bits are not stored.
    end else if (hit_stat) begin
      rd_word[PS_XOVER_VARIANT] = xover_variant;
      rd_word[PS_POLARITY] = polarity_rev;
      rd_word[PS_SPEED] = speed_100_o;
      rd_word[PS_DUPLEX] = full_duplex_o;
      rd_word[PS_MDI] = mdi_o;
      rd_word[PS_AN_DONE] = an_done;
      rd_word[PS_LINK_GOOD] = link_pass_o;
      rd_word[PS_PARTNER_LO +: ADV_W] = partner;
    end
  end

  // APB answer: one wait cycle so that ready and data come from flops.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else if (ce_i) begin
      // First access cycle latches the answer.
      if (access && !pready_o) begin
        pready_o <= 1'b1;
        // Unmapped addresses answer with an error.
        pslverr_o <= ~mapped;
        // Upper bits of the word read as zero.
        prdata_o <= {{(DATA_W - REG_W){1'b0}}, (pwrite_i ? {REG_W{1'b0}} : rd_word)};
      end else begin
        // The answer stands one cycle only.
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
        prdata_o <= '0;
      end
    end
  end

  // Cable diagnostic register: writable control bits only.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      force_link <= 1'b0;
      remote_loop <= 1'b0;
    end else if (ce_i && wr_ok && hit_cable) begin
      // Result, enable and fault count are not stored here, so writes miss them.
      // Writing zero does not abort a test.
      force_link <= merge(force_link, pwdata_i[CD_FORCE_LINK], wmask[CD_FORCE_LINK]);
      remote_loop <= merge(remote_loop, pwdata_i[CD_REMOTE_LOOP], wmask[CD_REMOTE_LOOP]);
    end
  end

  // Port control register.
  // Restart is stored; its pulse is made apart.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_off <= 1'b0;
      tx_dis <= 1'b0;
      an_restart <= 1'b0;
      mdix_dis <= 1'b0;
      force_mdi <= 1'b0;
      an_en <= RST_AN_EN;
      force_speed <= RST_FORCE_SPEED;
      force_duplex <= RST_FORCE_DUPLEX;
      adv <= RST_ADV;
    end else if (ce_i && wr_ok && hit_ctrl) begin
      led_off <= merge(led_off, pwdata_i[PC_LED_OFF], wmask[PC_LED_OFF]);
      tx_dis <= merge(tx_dis, pwdata_i[PC_TX_DIS], wmask[PC_TX_DIS]);
      an_restart <= merge(an_restart, pwdata_i[PC_AN_RESTART], wmask[PC_AN_RESTART]);
      mdix_dis <= merge(mdix_dis, pwdata_i[PC_MDIX_DIS], wmask[PC_MDIX_DIS]);
      force_mdi <= merge(force_mdi, pwdata_i[PC_FORCE_MDI], wmask[PC_FORCE_MDI]);
      an_en <= merge(an_en, pwdata_i[PC_AN_EN], wmask[PC_AN_EN]);
      force_speed <= merge(force_speed, pwdata_i[PC_FORCE_SPEED], wmask[PC_FORCE_SPEED]);
      force_duplex <= merge(force_duplex, pwdata_i[PC_FORCE_DUPLEX], wmask[PC_FORCE_DUPLEX]);
      // All five ability bits lie in the low byte.
      if (wmask[PC_ADV_LO]) begin
        adv <= pwdata_i[PC_ADV_LO +: ADV_W];
      end
    end
  end

  // Port status register: only the crossover variant bit is writable.
  // Read-only status bits ignore writes.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xover_variant <= RST_XOVER_VARIANT;
    end else if (ce_i && wr_ok && hit_stat) begin
      xover_variant <= merge(xover_variant, pwdata_i[PS_XOVER_VARIANT], wmask[PS_XOVER_VARIANT]);
    end
  end

  // Line status is sampled each cycle; it is synchronous to this clock.
  // The core shares this clock, so no synchroniser.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      polarity_rev <= 1'b0;
      an_done <= 1'b0;
      partner <= '0;
    end else if (ce_i) begin
      polarity_rev <= polarity_rev_i;
      an_done <= an_done_i;
      partner <= partner_i;
    end
  end

  // Restart pulse: one cycle for every write that carries a one.
  // A written zero leaves the pulse low.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      an_restart_o <= 1'b0;
    end else if (ce_i) begin
      an_restart_o <= wr_ok & hit_ctrl & wmask[PC_AN_RESTART] & pwdata_i[PC_AN_RESTART];
    end
  end

  // Registered copies of control bits that leave the block.
  // One cycle of lag buys pins straight from flops.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_led_n_o <= '1;
      link_pass_o <= 1'b0;
      remote_loop_o <= 1'b0;
      tx_disable_o <= 1'b0;
      an_enable_o <= RST_AN_EN;
      adv_o <= RST_ADV;
      auto_mdix_en_o <= 1'b1;
      crossover_variant_select_o <= RST_XOVER_VARIANT;
    end else if (ce_i) begin
      // LED pins are active low, so off means driven high.
      port_led_n_o <= led_off ? '1 : led_req_n_i;
      // Link good in status follows the forced value too.
      link_pass_o <= force_link | link_detect_i;
      remote_loop_o <= remote_loop;
      tx_disable_o <= tx_dis;
      an_enable_o <= an_en;
      adv_o <= adv;
      auto_mdix_en_o <= ~mdix_dis;
      crossover_variant_select_o <= xover_variant;
    end
  end

  // Cable test sequencer.
  // It owns the self-clearing enable and results.
  cable_diag_seq #(
    .FAULT_W(FAULT_W)
  ) u_cable_diag (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(cable_start),
    .busy_o(test_busy),
    .result_o(cable_result),
    .fault_count_o(fault_count),
    .test_req_o(cable_test_req_o),
    .done_i(cable_test_done_i),
    .result_i(cable_result_i),
    .fault_count_i(cable_fault_count_i)
  );

  // Speed, duplex and crossover resolution.
  // It reads the raw line inputs, not the copies.
  link_mode_resolve u_resolve (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .an_en_i(an_en),
    .force_speed_i(force_speed),
    .force_duplex_i(force_duplex),
    .mdix_dis_i(mdix_dis),
    .force_mdi_i(force_mdi),
    .adv_i(adv),
    .partner_i(partner_i),
    .an_done_i(an_done_i),
    .an_fail_i(an_fail_i),
    .sensed_speed_100_i(sensed_speed_100_i),
    .auto_mdi_i(auto_mdi_i),
    .speed_100_o(speed_100_o),
    .full_duplex_o(full_duplex_o),
    .mdi_o(mdi_o)
  );
endmodule : port_phy_control_status

/* File: verilog/pphy_pkg.sv */
package pphy_pkg;
  // Bus geometry: 32-bit data, each register on its own aligned word.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int FAULT_W = 9;
  localparam int LED_N = 4;
  localparam int ADV_W = 5;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [9:0] IDX_CABLE_DIAG = 10'h0F4;
  localparam logic [9:0] IDX_PORT_CTRL = 10'h0F6;
  localparam logic [9:0] IDX_PORT_STAT = 10'h0F8;

  // Cable diagnostic register fields.
  localparam int CD_RESULT_LO = 13;
  localparam int CD_TEST_EN = 12;
  localparam int CD_FORCE_LINK = 11;
  localparam int CD_REMOTE_LOOP = 9;
  localparam int CD_FAULT_LO = 0;

  // Port control register fields.
  localparam int PC_LED_OFF = 15;
  localparam int PC_TX_DIS = 14;
  localparam int PC_AN_RESTART = 13;
  localparam int PC_MDIX_DIS = 10;
  localparam int PC_FORCE_MDI = 9;
  localparam int PC_AN_EN = 7;
  localparam int PC_FORCE_SPEED = 6;
  localparam int PC_FORCE_DUPLEX = 5;
  localparam int PC_ADV_LO = 0;

  // Port status register fields.
  localparam int PS_XOVER_VARIANT = 15;
  localparam int PS_POLARITY = 13;
  localparam int PS_SPEED = 10;
  localparam int PS_DUPLEX = 9;
  localparam int PS_MDI = 7;
  localparam int PS_AN_DONE = 6;
  localparam int PS_LINK_GOOD = 5;
  localparam int PS_PARTNER_LO = 0;

  // Ability bits of advertised and partner words.
  localparam int AB_100F = 3;
  localparam int AB_100H = 2;
  localparam int AB_10F = 1;

  // Reset values of the stored bits.
  localparam logic RST_AN_EN = 1'b1;
  localparam logic RST_FORCE_SPEED = 1'b1;
  localparam logic RST_FORCE_DUPLEX = 1'b1;
  localparam logic [ADV_W-1:0] RST_ADV = 5'h1F;
  localparam logic RST_XOVER_VARIANT = 1'b1;
  localparam logic RST_MDI = 1'b1;

  // Cable test outcome codes.
  localparam logic [1:0] CABLE_NORMAL = 2'h0;
  localparam logic [1:0] CABLE_OPEN = 2'h1;
  localparam logic [1:0] CABLE_SHORT = 2'h2;
  localparam logic [1:0] CABLE_FAILED = 2'h3;

  // Byte address of a register from its printed index.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [9:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction : reg_addr
endpackage : pphy_pkg
